/* File: bench/lpmc_top_bench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "lpmc_consts.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
   $display("Error at %0t: got %0h expected %0h", $time, (g), (e)); end end
module lpmc_top_bench import lpmc_pkg::*; ;
   localparam logic [7:0] ST = `LPMC_OFS_STATE;
   localparam logic [7:0] EN = `LPMC_OFS_ENTER;
   localparam logic [7:0] IS = `LPMC_OFS_IRQST;
   localparam logic [7:0] PM = `LPMC_OFS_PWRMODE;
   localparam logic [7:0] LS = `LPMC_OFS_LPMSEL;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
   logic        cpu_clk_en, peripheral_clock_b_en, peripheral_clock_d_en, bclk_en;
   logic [31:0] haddr, hwdata, hrdata, irq_in, rdat;
   logic [1:0]  htrans, clk_src;
   logic [2:0]  hsize;
   logic [7:0]  blk_run;
   lpmc_rst_t   rst_src;
   lpmc_gate_t  gate;
   int          mismatches = 0, n_tests = 0, cyc = 0;
   int          n_cpu, n_pb, n_pd, n_bc;

   lpmc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .irq_in(irq_in), .rst_src(rst_src), .cpu_clk_en(cpu_clk_en),
      .peripheral_clock_b_en(peripheral_clock_b_en),
      .peripheral_clock_d_en(peripheral_clock_d_en), .bclk_en(bclk_en), .gate(gate),
      .clk_src(clk_src), .blk_run(blk_run), .irq(irq));
   lpmc_wake_src ws (.hclk(hclk), .irq_in(irq_in), .rst_src(rst_src));

   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   // ==========================================================
   // bus master
   // no wait count assumed; a hang is ended by the watchdog
   task automatic wait_rdy();
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      htrans <= 2'h2;
      hsel <= 1'b1;
      wait_rdy();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      wait_rdy();
      rdat = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask
   task automatic ck(input logic [7:0] a, input logic [31:0] e);
      xfer(a, 1'b0, 32'h0000_0000);
      `CHK(rdat, e)
   endtask
   // bounded poll, the settle time is not assumed here
   task automatic wait_st(input logic [31:0] e);
      int k;
      k = 0;
      do begin xfer(ST, 1'b0, 32'h0000_0000); k++; end while (rdat !== e && k < 200);
      `CHK(rdat, e)
   endtask
   // pulses sampled mid-cycle where they are settled
   task automatic count(input int n);
      n_cpu = 0;
      n_pb = 0;
      n_pd = 0;
      n_bc = 0;
      repeat (n) begin
         @(negedge hclk);
         n_cpu += int'(cpu_clk_en === 1'b1);
         n_pb += int'(peripheral_clock_b_en === 1'b1);
         n_pd += int'(peripheral_clock_d_en === 1'b1);
         n_bc += int'(bclk_en === 1'b1);
      end
      @(posedge hclk);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_reset();
      `CHK(gate, 7'h7E)
      `CHK(clk_src, 2'h3)
      `CHK(hresp, 1'b0)
      `CHK(hreadyout, 1'b1)
      `CHK(irq, 1'b0)
      ck(`LPMC_OFS_BLKEN, 32'h0000_00FF);
      ck(`LPMC_OFS_MSTOP, 32'h0000_00FF);
      ck(ST, 32'h0000_0000);
      ck(8'h40, 32'h0000_0000);
   endtask
   task automatic t_modes();
      for (int s = 0; s < 4; s++) begin
         wr(`LPMC_OFS_CLKSRC, s);
         @(posedge hclk);
         `CHK(clk_src, s[1:0])
      end
      for (int m = 0; m < 4; m++) begin
         wr(PM, m);
         ck(PM, m);
      end
      wr(PM, 32'h0000_0005);
      ck(PM, 32'h0000_0003);
      wr(PM, 32'h0000_0004);
      ck(PM, 32'h0000_0003);
      wr(`LPMC_OFS_CLKSRC, 32'h0000_0002);
      wr(PM, 32'h0000_0004);
      ck(PM, 32'h0000_0004);
      wr(`LPMC_OFS_CLKSRC, 32'h0000_0001);
      ck(`LPMC_OFS_CLKSRC, 32'h0000_0002);
      wr(PM, 32'h0000_0002);
      wr(`LPMC_OFS_CLKSRC, 32'h0000_0001);
      ck(`LPMC_OFS_CLKSRC, 32'h0000_0001);
   endtask
   // window of 24 holds whole periods of 2, 3, 4 and 1
   task automatic t_div();
      wr(`LPMC_OFS_CLKDIV, 32'h0102_0300);
      repeat (8) @(posedge hclk);
      count(24);
      `CHK(n_cpu, 12)
      `CHK(n_pb, 8)
      `CHK(n_pd, 6)
      `CHK(n_bc, 24)
      wr(`LPMC_OFS_BLKEN, 32'h0000_00F0);
      wr(`LPMC_OFS_MSTOP, 32'h0000_0030);
      @(posedge hclk);
      `CHK(blk_run, 8'hC0)
   endtask
   task automatic t_sleep();
      wr(LS, 32'h0000_0000);
      wr(`LPMC_OFS_IRQMSK, 32'h0000_0000);
      wr(EN, 32'h0000_0001);
      ck(ST, 32'h0000_0001);
      `CHK(gate.core_clk_en, 1'b0)
      `CHK(gate.periph_clk_en, 1'b1)
      count(24);
      `CHK(n_cpu, 0)
      `CHK(n_pb, 8)
      `CHK(blk_run, 8'hC0)
      `CHK(irq, 1'b0)
      ws.raise(32'h0000_0020, '0, 2);
      ws.drop();
      ck(ST, 32'h0000_0000);
      ck(PM, 32'h0000_0002);
      ck(IS, 32'h0000_0003);
      wr(`LPMC_OFS_IRQMSK, 32'h0000_0002);
      @(posedge hclk);
      `CHK(irq, 1'b1)
      wr(IS, 32'h0000_0003);
      @(posedge hclk);
      `CHK(irq, 1'b0)
      for (int i = 0; i < 6; i++) begin
         wr(EN, 32'h0000_0001);
         ck(ST, 32'h0000_0001);
         ws.raise(32'h0000_0000, lpmc_rst_t'(6'h01 << i), 0);
         ws.drop();
         ck(ST, 32'h0000_0000);
      end
   endtask
   task automatic t_stby();
      wr(IS, 32'h0000_0007);
      wr(`LPMC_OFS_WAKEEN, 32'h0000_0001);
      wr(`LPMC_OFS_SNZEN, 32'h0000_0000);
      wr(LS, 32'h0000_0001);
      wr(EN, 32'h0000_0001);
      ck(ST, 32'h0000_0002);
      `CHK(gate.core_clk_en, 1'b0)
      `CHK(gate.periph_clk_en, 1'b0)
      `CHK(gate.osc_en, 1'b0)
      `CHK(gate.sram_pwr, 1'b1)
      `CHK(blk_run, 8'h00)
      wr(PM, 32'h0000_0000);
      ck(PM, 32'h0000_0002);
      ws.raise(32'h0000_0010, '0, 1);
      repeat (8) @(posedge hclk);
      ws.drop();
      ck(ST, 32'h0000_0002);
      ws.raise(32'h0000_0001, '0, 3);
      ws.drop();
      ck(ST, 32'h0000_0005);
      repeat (30) @(posedge hclk);
      ck(ST, 32'h0000_0005);
      wait_st(32'h0000_0000);
      `CHK(gate.core_clk_en, 1'b1)
      `CHK(gate.osc_en, 1'b1)
      ck(PM, 32'h0000_0002);
      ck(IS, 32'h0000_0003);
      ck(`LPMC_OFS_WAKESRC, 32'h0000_0001);
   endtask
   task automatic t_snooze();
      wr(IS, 32'h0000_0007);
      wr(`LPMC_OFS_SNZEN, 32'h0000_0002);
      wr(EN, 32'h0000_0001);
      ck(ST, 32'h0000_0002);
      ws.raise(32'h0000_0002, '0, 0);
      ws.drop();
      ck(ST, 32'h0000_0003);
      ck(IS, 32'h0000_0005);
      `CHK(gate.core_clk_en, 1'b0)
      ws.raise(32'h0000_0001, '0, 2);
      ws.drop();
      ck(ST, 32'h0000_0005);
      wait_st(32'h0000_0000);
   endtask
   task automatic t_deep();
      wr(LS, 32'h0000_0003);
      ck(LS, 32'h0000_0001);
      wr(LS, 32'h0000_0002);
      wr(EN, 32'h0000_0001);
      ck(ST, 32'h0000_0004);
      `CHK(gate.osc_en, 1'b0)
      `CHK(gate.sram_pwr, 1'b0)
      `CHK(gate.flash_pwr, 1'b0)
      `CHK(gate.core_pwr, 1'b0)
      `CHK(gate.io_hold, 1'b1)
      ws.raise(32'h0000_0001, '0, 0);
      repeat (4) @(posedge hclk);
      ws.drop();
      ck(ST, 32'h0000_0004);
      ws.raise(32'h0000_0000, lpmc_rst_t'(6'h04), 0);
      ws.drop();
      ck(ST, 32'h0000_0005);
      wait_st(32'h0000_0000);
      `CHK(gate.io_hold, 1'b0)
   endtask
   // reset in mid-run, from deep standby, must bring back the defaults that t_reset checks and the run mode
   task automatic t_rerun();
      wr(EN, 32'h0000_0001);
      ck(ST, 32'h0000_0004);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      ck(PM, 32'h0000_0000);
   endtask
   // ==========================================================
   // verdict
   task automatic results();
      $display("mismatches %0d n_tests %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // a hung handshake ends here instead of running forever
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         results();
      end
   end
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_modes();
      t_div();
      t_sleep();
      t_stby();
      t_snooze();
      t_deep();
      t_rerun();
      results();
   end
endmodule
`default_nettype wire

/* File: bench/lpmc_wake_src.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// wake sources: peripheral interrupt and reset request levels
module lpmc_wake_src import lpmc_pkg::*; (
   input  wire logic   hclk,    // system clock
   output logic [31:0] irq_in,  // interrupt levels
   output lpmc_rst_t   rst_src  // reset requests
);
   initial begin
      irq_in = 32'h0000_0000;
      rst_src = '0;
   end
   // a slow source raises its line only dly edges after being asked
   task automatic raise(input logic [31:0] irq, input lpmc_rst_t rst, input int dly);
      repeat (dly) @(posedge hclk);
      irq_in <= irq;
      rst_src <= rst;
      @(posedge hclk);
   endtask
   task automatic drop();
      irq_in <= 32'h0000_0000;
      rst_src <= '0;
      @(posedge hclk);
   endtask
endmodule
`default_nettype wire

/* File: src/lpmc_consts.svh */
`ifndef LPMC_CONSTS_SVH
`define LPMC_CONSTS_SVH
// ==========================================================
// register byte offsets
`define LPMC_OFS_PWRMODE   8'h00
`define LPMC_OFS_CLKSRC    8'h04
`define LPMC_OFS_CLKDIV    8'h08
`define LPMC_OFS_LPMSEL    8'h0C
`define LPMC_OFS_ENTER     8'h10
`define LPMC_OFS_WAKEEN    8'h14
`define LPMC_OFS_SNZEN     8'h18
`define LPMC_OFS_BLKEN     8'h1C
`define LPMC_OFS_MSTOP     8'h20
`define LPMC_OFS_STATE     8'h24
`define LPMC_OFS_IRQST     8'h28
`define LPMC_OFS_IRQMSK    8'h2C
`define LPMC_OFS_WAKESRC   8'h30
// ==========================================================
// reset values
`define LPMC_RST_CLKDIV    32'h0000_0000
`define LPMC_RST_BLKEN     8'hFF
`define LPMC_RST_MSTOP     8'hFF
// ==========================================================
// interrupt status bit positions
`define LPMC_IRQ_ENTER     0
`define LPMC_IRQ_WAKE      1
`define LPMC_IRQ_SNOOZE    2
// ==========================================================
// timing: oscillator restart settle time
`define LPMC_SETTLE_NS     400
`define LPMC_CLK_NS        8
`define LPMC_SETTLE_CYC    ((`LPMC_SETTLE_NS + `LPMC_CLK_NS - 1) / `LPMC_CLK_NS)
`endif

/* File: src/lpmc_divider.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// programmable divide: one-cycle enable every div+1 clocks
module lpmc_divider (
   input  wire logic       hclk,    // system clock
   input  wire logic       hresetn, // async reset, active low
   input  wire logic       run,     // counting allowed
   input  wire logic [7:0] div,     // ratio minus one
   output logic            tick     // clock enable pulse
);
   logic [7:0] cnt_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_ff <= 8'h00;
         tick   <= 1'b0;
      end else if (!run) begin
         cnt_ff <= 8'h00;
         tick   <= 1'b0;
      end else if (cnt_ff >= div) begin
         cnt_ff <= 8'h00;
         tick   <= 1'b1;
      end else begin
         cnt_ff <= cnt_ff + 8'h01;
         tick   <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: src/lpmc_pkg.sv */
`default_nettype none
package lpmc_pkg;
   typedef enum logic [2:0] {
      LPMC_HIGH_SPEED, LPMC_MIDDLE_SPEED, LPMC_LOW_VOLTAGE,
      LPMC_LOW_SPEED, LPMC_SUBOSC_SPEED
   } lpmc_pwrmode_t;

   typedef enum logic [1:0] {
      LPMC_SRC_EXT_CLK, LPMC_SRC_MAIN_OSC, LPMC_SRC_SUB_OSC, LPMC_SRC_HOCO
   } lpmc_clksrc_t;

   typedef enum logic [1:0] {
      LPMC_LPM_SLEEP, LPMC_LPM_SWSTBY, LPMC_LPM_DEEP
   } lpmc_lpmsel_t;

   typedef enum logic [2:0] {
      LPMC_ST_NORMAL, LPMC_ST_SLEEP, LPMC_ST_SWSTBY,
      LPMC_ST_SNOOZE, LPMC_ST_DEEP, LPMC_ST_WAKE
   } lpmc_state_t;

   typedef struct packed {
      logic [7:0] core_div;
      logic [7:0] peripheral_clock_b_div;
      logic [7:0] peripheral_clock_d_div;
      logic [7:0] bclk_div;
   } lpmc_clkdiv_t;

   typedef struct packed {
      logic core_clk_en;
      logic periph_clk_en;
      logic osc_en;
      logic sram_pwr;
      logic flash_pwr;
      logic core_pwr;
      logic io_hold;
   } lpmc_gate_t;

   typedef struct packed {
      logic ext_pin;
      logic power_on;
      logic volt_mon;
      logic parity;
      logic indep_wdt;
      logic win_wdt;
   } lpmc_rst_t;
endpackage
`default_nettype wire

/* File: src/lpmc_top.sv */
// Overview of operation
// - five run modes, high, middle, low-voltage, low, sub-osc speed, with allowed sources
// - system clock source selects external clock, main osc, sub osc or on-chip osc
// - core, two peripheral and bus clock enables from separate division ratios
// - low-power states sleep, software standby, deep standby and snooze
// - sleep stops cpu clock only; peripherals keep running
// - sleep ends on any interrupt or any listed reset
// - software standby gates cpu, peripherals, oscillators; retains contents and pins
// - software standby ends on interrupts enabled in wake enable register or on any listed reset
// - deep standby also stops oscillators, sram, flash, powers core off, holds pins
// - snooze keeps selected peripherals running while cpu sleeps
// - snooze entered only from standby; exits on standby wake sources
// - block enable bits and module-stop bits switch selectable blocks
`timescale 1ns/100ps
`default_nettype none
`include "lpmc_consts.svh"
module lpmc_top import lpmc_pkg::*; (
   input  wire logic        hclk,        // system clock
   input  wire logic        hresetn,     // async reset, active low
   input  wire logic        hsel,        // slave select
   input  wire logic [31:0] haddr,       // address
   input  wire logic [1:0]  htrans,      // transfer type
   input  wire logic        hwrite,      // write
   input  wire logic [2:0]  hsize,       // size
   input  wire logic [31:0] hwdata,      // write data
   input  wire logic        hready,      // bus ready
   output logic [31:0]      hrdata,      // read data
   output logic             hreadyout,   // slave ready
   output logic             hresp,       // response
   input  wire logic [31:0] irq_in,      // peripheral interrupts
   input  wire lpmc_rst_t   rst_src,     // wake-capable reset requests
   output logic             cpu_clk_en,  // core_system_clock enable pulse
   output logic             peripheral_clock_b_en, // peripheral_clock_b enable pulse
   output logic             peripheral_clock_d_en, // peripheral_clock_d enable pulse
   output logic             bclk_en,     // external bus clock enable pulse
   output lpmc_gate_t       gate,        // gating and power controls
   output logic [1:0]       clk_src,     // selected system clock source
   output logic [7:0]       blk_run,     // selectable blocks running
   output logic             irq          // interrupt level
);
   // =======================================================
   // registers
   lpmc_pwrmode_t pwrmode_ff;
   lpmc_clksrc_t  clksrc_ff;
   lpmc_clkdiv_t  clkdiv_ff;
   lpmc_lpmsel_t  lpmsel_ff;
   logic [31:0]   wake_interrupt_enable_ff;
   logic [31:0]   snooze_en_ff;
   logic [7:0]    blken_ff;
   logic [7:0]    mstop_ff;
   logic [2:0]    irqst_ff;
   logic [2:0]    irqmsk_ff;
   logic [31:0]   wakesrc_ff;
   lpmc_state_t   state_ff;
   lpmc_state_t   nxt_state;
   logic [7:0]    settle_ff;
   logic          enter_req;

   // =======================================================
   // bus slave, zero wait states
   logic        ap_wr_ff;
   logic        ap_rd_ff;
   logic [7:0]  ap_addr_ff;
   logic        ap_take;

   assign ap_take   = hsel && hready && htrans[1];
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_wr_ff   <= 1'b0;
         ap_rd_ff   <= 1'b0;
         ap_addr_ff <= 8'h00;
      end else if (hready) begin
         ap_wr_ff   <= ap_take && hwrite;
         ap_rd_ff   <= ap_take && !hwrite;
         ap_addr_ff <= haddr[7:0];
      end
   end

   function automatic logic wr_hit(input logic [7:0] ofs);
      wr_hit = ap_wr_ff && (ap_addr_ff == ofs);
   endfunction

   // only modes in the list are stored; unused codes are refused
   function automatic logic mode_src_ok(input logic [2:0] m, input logic [1:0] s);
      if (m > 3'h4)
         mode_src_ok = 1'b0;
      else if (m == 3'h4)
         mode_src_ok = (s == 2'h2);
      else
         mode_src_ok = 1'b1;
   endfunction

   assign enter_req = wr_hit(`LPMC_OFS_ENTER) && hwdata[0];

   // run configuration only changes while running normally
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pwrmode_ff <= LPMC_HIGH_SPEED;
         clksrc_ff  <= LPMC_SRC_HOCO;
         clkdiv_ff  <= `LPMC_RST_CLKDIV;
      end else if (state_ff == LPMC_ST_NORMAL) begin
         if (wr_hit(`LPMC_OFS_PWRMODE) && mode_src_ok(hwdata[2:0], clksrc_ff))
            pwrmode_ff <= lpmc_pwrmode_t'(hwdata[2:0]);
         if (wr_hit(`LPMC_OFS_CLKSRC) && mode_src_ok(pwrmode_ff, hwdata[1:0]))
            clksrc_ff <= lpmc_clksrc_t'(hwdata[1:0]);
         if (wr_hit(`LPMC_OFS_CLKDIV))
            clkdiv_ff <= hwdata;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lpmsel_ff                <= LPMC_LPM_SLEEP;
         wake_interrupt_enable_ff <= 32'h0000_0000;
         snooze_en_ff             <= 32'h0000_0000;
         blken_ff                 <= `LPMC_RST_BLKEN;
         mstop_ff                 <= `LPMC_RST_MSTOP;
         irqmsk_ff                <= 3'h0;
      end else begin
         if (wr_hit(`LPMC_OFS_LPMSEL) && hwdata[1:0] != 2'h3)
            lpmsel_ff <= lpmc_lpmsel_t'(hwdata[1:0]);
         if (wr_hit(`LPMC_OFS_WAKEEN))
            wake_interrupt_enable_ff <= hwdata;
         if (wr_hit(`LPMC_OFS_SNZEN))
            snooze_en_ff <= hwdata;
         if (wr_hit(`LPMC_OFS_BLKEN))
            blken_ff <= hwdata[7:0];
         if (wr_hit(`LPMC_OFS_MSTOP))
            mstop_ff <= hwdata[7:0];
         if (wr_hit(`LPMC_OFS_IRQMSK))
            irqmsk_ff <= hwdata[2:0];
      end
   end

   // =======================================================
   // wake qualification
   logic any_rst;
   logic sleep_wake;
   logic stby_wake;
   logic snooze_trig;

   assign any_rst    = |rst_src;
   assign sleep_wake = (|irq_in) || any_rst;
   assign stby_wake  = (|(irq_in & wake_interrupt_enable_ff)) || any_rst;
   assign snooze_trig = |(irq_in & snooze_en_ff);

   // =======================================================
   // low-power state machine
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         LPMC_ST_NORMAL: begin
            if (enter_req) begin
               case (lpmsel_ff)
                  LPMC_LPM_SLEEP:  nxt_state = LPMC_ST_SLEEP;
                  LPMC_LPM_SWSTBY: nxt_state = LPMC_ST_SWSTBY;
                  LPMC_LPM_DEEP:   nxt_state = LPMC_ST_DEEP;
                  default:         nxt_state = LPMC_ST_NORMAL;
               endcase
            end
         end
         LPMC_ST_SLEEP: begin
            if (sleep_wake)
               nxt_state = LPMC_ST_NORMAL;
         end
         LPMC_ST_SWSTBY: begin
            if (stby_wake)
               nxt_state = LPMC_ST_WAKE;
            else if (snooze_trig)
               nxt_state = LPMC_ST_SNOOZE;
         end
         LPMC_ST_SNOOZE: begin
            if (stby_wake)
               nxt_state = LPMC_ST_WAKE;
         end
         LPMC_ST_DEEP: begin
            // only a reset leaves deep standby; core state is lost
            if (any_rst)
               nxt_state = LPMC_ST_WAKE;
         end
         LPMC_ST_WAKE: begin
            if (settle_ff == 8'h00)
               nxt_state = LPMC_ST_NORMAL;
         end
         default: nxt_state = LPMC_ST_NORMAL;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         state_ff <= LPMC_ST_NORMAL;
      else
         state_ff <= nxt_state;
   end

   // oscillators need time before clocks restart
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         settle_ff <= 8'h00;
      else if (nxt_state == LPMC_ST_WAKE && state_ff != LPMC_ST_WAKE)
         settle_ff <= 8'(`LPMC_SETTLE_CYC - 1);
      else if (settle_ff != 8'h00)
         settle_ff <= settle_ff - 8'h01;
   end

   // record which interrupts caused the wake
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         wakesrc_ff <= 32'h0000_0000;
      else if (state_ff == LPMC_ST_SLEEP && sleep_wake)
         wakesrc_ff <= irq_in;
      else if ((state_ff == LPMC_ST_SWSTBY || state_ff == LPMC_ST_SNOOZE) && stby_wake)
         wakesrc_ff <= irq_in & wake_interrupt_enable_ff;
   end

   // =======================================================
   // gating per state
   always_comb begin
      gate = '{default: 1'b1};
      gate.io_hold = 1'b0;
      case (state_ff)
         LPMC_ST_SLEEP: gate.core_clk_en = 1'b0;
         LPMC_ST_SWSTBY: begin
            gate.core_clk_en   = 1'b0;
            gate.periph_clk_en = 1'b0;
            gate.osc_en        = 1'b0;
            gate.io_hold       = 1'b1;
         end
         LPMC_ST_SNOOZE: begin
            gate.core_clk_en = 1'b0;
            gate.io_hold     = 1'b1;
         end
         LPMC_ST_DEEP: begin
            gate.core_clk_en   = 1'b0;
            gate.periph_clk_en = 1'b0;
            gate.osc_en        = 1'b0;
            gate.sram_pwr      = 1'b0;
            gate.flash_pwr     = 1'b0;
            gate.core_pwr      = 1'b0;
            gate.io_hold       = 1'b1;
         end
         LPMC_ST_WAKE: begin
            gate.core_clk_en   = 1'b0;
            gate.periph_clk_en = 1'b0;
            gate.io_hold       = 1'b1;
         end
         default: gate.io_hold = 1'b0;
      endcase
   end

   // snooze runs only the blocks that software enabled
   assign blk_run = blken_ff & ~mstop_ff
                    & {8{gate.periph_clk_en && gate.core_pwr}};
   assign clk_src = clksrc_ff;

   // =======================================================
   // clock dividers
   lpmc_divider u_div_core (
      .hclk    (hclk),
      .hresetn (hresetn),
      .run     (gate.core_clk_en),
      .div     (clkdiv_ff.core_div),
      .tick    (cpu_clk_en)
   );
   lpmc_divider u_div_pb (
      .hclk    (hclk),
      .hresetn (hresetn),
      .run     (gate.periph_clk_en),
      .div     (clkdiv_ff.peripheral_clock_b_div),
      .tick    (peripheral_clock_b_en)
   );
   lpmc_divider u_div_pd (
      .hclk    (hclk),
      .hresetn (hresetn),
      .run     (gate.periph_clk_en),
      .div     (clkdiv_ff.peripheral_clock_d_div),
      .tick    (peripheral_clock_d_en)
   );
   lpmc_divider u_div_bclk (
      .hclk    (hclk),
      .hresetn (hresetn),
      .run     (gate.periph_clk_en),
      .div     (clkdiv_ff.bclk_div),
      .tick    (bclk_en)
   );

   // =======================================================
   // interrupts: set beats write-one clear
   logic [2:0] irq_evt;
   assign irq_evt[`LPMC_IRQ_ENTER] = (state_ff == LPMC_ST_NORMAL) && (nxt_state != LPMC_ST_NORMAL);
   assign irq_evt[`LPMC_IRQ_WAKE]  = (state_ff != LPMC_ST_NORMAL) && (nxt_state == LPMC_ST_NORMAL);
   assign irq_evt[`LPMC_IRQ_SNOOZE] = (nxt_state == LPMC_ST_SNOOZE)
                                      && (state_ff != LPMC_ST_SNOOZE);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         irqst_ff <= 3'h0;
      else if (wr_hit(`LPMC_OFS_IRQST))
         irqst_ff <= (irqst_ff & ~hwdata[2:0]) | irq_evt;
      else
         irqst_ff <= irqst_ff | irq_evt;
   end

   assign irq = |(irqst_ff & irqmsk_ff);

   // =======================================================
   // read data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (ap_take && !hwrite) begin
         case (haddr[7:0])
            `LPMC_OFS_PWRMODE: hrdata <= {29'h0, pwrmode_ff};
            `LPMC_OFS_CLKSRC:  hrdata <= {30'h0, clksrc_ff};
            `LPMC_OFS_CLKDIV:  hrdata <= clkdiv_ff;
            `LPMC_OFS_LPMSEL:  hrdata <= {30'h0, lpmsel_ff};
            `LPMC_OFS_WAKEEN:  hrdata <= wake_interrupt_enable_ff;
            `LPMC_OFS_SNZEN:   hrdata <= snooze_en_ff;
            `LPMC_OFS_BLKEN:   hrdata <= {24'h0, blken_ff};
            `LPMC_OFS_MSTOP:   hrdata <= {24'h0, mstop_ff};
            `LPMC_OFS_STATE:   hrdata <= {29'h0, state_ff};
            `LPMC_OFS_IRQST:   hrdata <= {29'h0, irqst_ff};
            `LPMC_OFS_IRQMSK:  hrdata <= {29'h0, irqmsk_ff};
            `LPMC_OFS_WAKESRC: hrdata <= wakesrc_ff;
            default:           hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // =======================================================
   // checks
   sleep_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      state_ff == LPMC_ST_SLEEP |-> !gate.core_clk_en && gate.periph_clk_en)
      else $error("sleep gating wrong");
   sleep_exit_a: assert property (@(posedge hclk) disable iff (!hresetn)
      state_ff == LPMC_ST_SLEEP && sleep_wake |=> state_ff == LPMC_ST_NORMAL)
      else $error("sleep did not exit");
   stby_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      state_ff == LPMC_ST_SWSTBY && !stby_wake && !snooze_trig |=> state_ff == LPMC_ST_SWSTBY)
      else $error("standby left without wake");
   stby_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      state_ff == LPMC_ST_SWSTBY |-> !gate.osc_en && gate.io_hold && gate.sram_pwr)
      else $error("standby gating wrong");
   deep_pwr_a: assert property (@(posedge hclk) disable iff (!hresetn)
      state_ff == LPMC_ST_DEEP |-> !gate.core_pwr && !gate.sram_pwr && gate.io_hold)
      else $error("deep standby power wrong");
   snooze_from_a: assert property (@(posedge hclk) disable iff (!hresetn)
      state_ff == LPMC_ST_SNOOZE && $past(state_ff) != LPMC_ST_SNOOZE
      |-> $past(state_ff) == LPMC_ST_SWSTBY)
      else $error("snooze not from standby");
   sequence wake_start_s;
      state_ff != LPMC_ST_WAKE ##1 state_ff == LPMC_ST_WAKE;
   endsequence
   wake_resume_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wake_start_s |-> ##[1:60] state_ff == LPMC_ST_NORMAL)
      else $error("wake did not resume");
   mode_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
      state_ff != LPMC_ST_NORMAL |=> $stable(pwrmode_ff))
      else $error("run mode changed in low power");
   irq_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
      |irq_evt |=> (irqst_ff & $past(irq_evt)) == $past(irq_evt))
      else $error("status event lost");
endmodule
`default_nettype wire
